/* File: hdl/pcg_clock_gate_ctl.sv */
// Peripheral clock gates and backup domain control behind an Avalon-MM slave.
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Overview of operation
// - Gate register answers at once unless a low-speed bus transfer is busy or CE_IN is low.
// - Reads of a peripheral whose clock is off return zero.
// - Bits 30..27 gate consumer control, analog out, power and backup interfaces.
// - Bits 22..17 gate two I2C, two async ports, two serial ports.
// - Bits 15, 14 gate two SPI controllers, bit 11 the window watchdog.
// - Bits 8..0 gate timers 14,13,12,7,6,5,4,3,2; all read-write.
// - Reserved gate register bits always read zero.
// - Word, half-word and byte access; narrow writes touch only enabled lanes.
// - Backup register at 0x20, zero at reset, fields cleared only by backup reset.
// - Backup fields other than the bit 16 reset ignore writes until the power unit grants write permission.
// - Successive backup register accesses see zero to three wait states.
// - Bit 16 holds the whole backup domain in reset while one.
// - Bit 15 enables the calendar clock.
// - Bits 9:8 pick calendar source: none, slow ext, slow int, fast ext/128.
// - A chosen calendar source is locked until backup domain reset.
// - Bypass bit writable only while the slow crystal is off.
// - Ready bit read-only; drops six oscillator cycles after enable clears.
// - Bit 0 switches the slow external crystal on or off.
// - Reserved backup register bits always read zero.
module pcg_clock_gate_ctl #(
    parameter int unsigned BKP_GAP = pcg_pkg::BKP_MAX_WAIT,
    parameter int unsigned READY_DROP = pcg_pkg::XTAL_DROP_EDGES
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic BKP_NRST_IN,
    input wire logic CE_IN,
    input wire logic [pcg_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic PERIPH_BUS_BUSY_IN,
    input wire logic BACKUP_WRITE_PERMIT_IN,
    input wire logic SLOW_XTAL_STABLE_IN,
    input wire logic SLOW_XTAL_CLK_IN,
    input wire logic [4:0] PERIPH_SEL_IN,
    input wire logic [31:0] PERIPH_RDATA_IN,
    output logic [31:0] PERIPH_RDATA_OUT,
    output pcg_pkg::pcg_gates_s PERIPH_CLK_ON_OUT,
    output pcg_pkg::pcg_bkp_out_s BACKUP_CTL_OUT
);
    // ==================================================
    // Parameter checks
    if (BKP_GAP < 1 || BKP_GAP > 3) begin : g_bad_gap
        $error("BKP_GAP must lie in 1..3");
    end
    if (READY_DROP < 1 || READY_DROP > 7) begin : g_bad_drop
        $error("READY_DROP must lie in 1..7");
    end

    // ==================================================
    // State
    // System-reset state and backup-reset state are kept apart, because the
    // backup fields must survive every reset except the backup domain's own.
    typedef struct packed {
        logic [31:0] gates;
        logic [1:0] gap;
        logic [31:0] rdata;
    } pcg_sys_s;
    typedef struct packed {
        logic sw_reset;
        logic cal_on;
        logic [1:0] src;
        logic bypass;
        logic on;
        logic ready;
        logic [2:0] drop_cnt;
        logic stable_meta;
        logic stable_sync;
        logic osc_meta;
        logic osc_sync;
        logic osc_prev;
    } pcg_bkp_s;

    pcg_sys_s sys;
    pcg_sys_s next_sys;
    pcg_bkp_s bkp;
    pcg_bkp_s next_bkp;

    logic req;
    logic hit_gates;
    logic hit_bkp;
    logic done;
    logic bkp_write;
    logic sel_on;
    logic osc_edge;
    logic [31:0] bkp_word;
    logic [31:0] bkp_merged;

    function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ==================================================
    // Bus decode and handshake
    assign req = AVS_READ_IN | AVS_WRITE_IN;
    assign hit_gates = (AVS_ADDRESS_IN[7:2] == pcg_pkg::GATES_OFS[7:2]);
    assign hit_bkp = (AVS_ADDRESS_IN[7:2] == pcg_pkg::BKP_OFS[7:2]);
    // A frozen block must not let a write slip past, so a low enable stalls.
    assign AVS_WAITREQUEST_OUT = req & (~CE_IN
                               | (hit_gates & PERIPH_BUS_BUSY_IN)
                               | (hit_bkp & (sys.gap != 2'h0)));
    assign done = req & ~AVS_WAITREQUEST_OUT;
    assign bkp_write = done & AVS_WRITE_IN & hit_bkp;

    // Reserved bits are built in as constant zeros.
    assign bkp_word = {15'h0000, bkp.sw_reset, bkp.cal_on, 5'h00, bkp.src,
                       5'h00, bkp.bypass, bkp.ready, bkp.on};
    assign bkp_merged = merge_lanes(bkp_word, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);

    always_comb begin
        AVS_READDATA_OUT = 32'h00000000;
        if (AVS_READ_IN && hit_gates) begin
            AVS_READDATA_OUT = sys.gates & pcg_pkg::GATES_RW_MASK;
        end else if (AVS_READ_IN && hit_bkp) begin
            AVS_READDATA_OUT = bkp_word;
        end
    end

    // ==================================================
    // System-reset state: gate register, spacing counter, read-back gate
    assign sel_on = sys.gates[PERIPH_SEL_IN];

    always_comb begin
        next_sys = sys;
        if (sys.gap != 2'h0) begin
            next_sys.gap = sys.gap - 2'h1;
        end
        if (done && hit_bkp) begin
            next_sys.gap = BKP_GAP[1:0];
        end
        if (done && AVS_WRITE_IN && hit_gates) begin
            next_sys.gates = merge_lanes(sys.gates, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN)
                             & pcg_pkg::GATES_RW_MASK;
        end
        next_sys.rdata = sel_on ? PERIPH_RDATA_IN : 32'h00000000;
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sys <= '{gates: pcg_pkg::GATES_RESET, gap: 2'h0, rdata: 32'h00000000};
        end else if (CE_IN) begin
            sys <= next_sys;
        end
    end

    assign PERIPH_CLK_ON_OUT = pcg_pkg::pcg_gates_s'(sys.gates & pcg_pkg::GATES_RW_MASK);
    assign PERIPH_RDATA_OUT = sys.rdata;

    // ==================================================
    // Backup-reset state: crystal, calendar clock and domain reset
    assign osc_edge = bkp.osc_sync & ~bkp.osc_prev;

    always_comb begin
        next_bkp = bkp;
        next_bkp.stable_meta = SLOW_XTAL_STABLE_IN;
        next_bkp.stable_sync = bkp.stable_meta;
        next_bkp.osc_meta = SLOW_XTAL_CLK_IN;
        next_bkp.osc_sync = bkp.osc_meta;
        next_bkp.osc_prev = bkp.osc_sync;
        if (bkp_write) begin
            next_bkp.sw_reset = bkp_merged[pcg_pkg::SWRST_BIT];
        end
        if (bkp_write && BACKUP_WRITE_PERMIT_IN) begin
            next_bkp.cal_on = bkp_merged[pcg_pkg::CAL_ON_BIT];
            next_bkp.on = bkp_merged[pcg_pkg::ON_BIT];
            if (bkp.src == pcg_pkg::SRC_NONE) begin
                next_bkp.src = bkp_merged[pcg_pkg::SRC_LSB +: 2];
            end
            if (!bkp.on) begin
                next_bkp.bypass = bkp_merged[pcg_pkg::BYP_BIT];
            end
        end
        if (bkp.on) begin
            next_bkp.ready = bkp.stable_sync;
            next_bkp.drop_cnt = 3'h0;
        end else if (bkp.ready && osc_edge) begin
            if (bkp.drop_cnt == 3'(READY_DROP - 1)) begin
                next_bkp.ready = 1'b0;
                next_bkp.drop_cnt = 3'h0;
            end else begin
                next_bkp.drop_cnt = bkp.drop_cnt + 3'h1;
            end
        end
        // The software reset clears the domain but leaves the reset bit itself
        // under software control, otherwise it could never be released.
        if (bkp.sw_reset) begin
            next_bkp.cal_on = 1'b0;
            next_bkp.src = pcg_pkg::SRC_NONE;
            next_bkp.bypass = 1'b0;
            next_bkp.on = 1'b0;
            next_bkp.ready = 1'b0;
            next_bkp.drop_cnt = 3'h0;
        end
    end

    always_ff @(posedge CLK_IN or negedge BKP_NRST_IN) begin
        if (!BKP_NRST_IN) begin
            bkp <= '0;
        end else if (CE_IN) begin
            bkp <= next_bkp;
        end
    end

    assign BACKUP_CTL_OUT = '{backup_domain_sw_reset: bkp.sw_reset,
                              calendar_clk_on: bkp.cal_on,
                              calendar_clk_source: bkp.src,
                              slow_xtal_bypass: bkp.bypass,
                              slow_xtal_on: bkp.on,
                              slow_xtal_ready: bkp.ready};

    // ==================================================
    // Assertions
    a_gate_busy_stall: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (req && hit_gates && PERIPH_BUS_BUSY_IN) |-> AVS_WAITREQUEST_OUT)
        else $error("gate register answered during a busy bus transfer");

    a_gate_no_wait: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (req && hit_gates && !PERIPH_BUS_BUSY_IN && CE_IN) |-> !AVS_WAITREQUEST_OUT)
        else $error("gate register stalled with the bus idle");

    a_gated_read_zero: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && !sys.gates[PERIPH_SEL_IN]) |=> (PERIPH_RDATA_OUT == 32'h00000000))
        else $error("read of a gated peripheral was not zero");

    a_gate_reserved_zero: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (AVS_READ_IN && hit_gates) |-> ((AVS_READDATA_OUT & ~pcg_pkg::GATES_RW_MASK) == 32'h0))
        else $error("reserved gate bits read as one");

    a_byte_lane_keep: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (done && AVS_WRITE_IN && hit_gates && !AVS_BYTEENABLE_IN[0])
        |=> (sys.gates[7:0] == $past(sys.gates[7:0])))
        else $error("disabled byte lane was written");

    a_permit_needed: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp_write && !BACKUP_WRITE_PERMIT_IN && !bkp.sw_reset)
        |=> (bkp.on == $past(bkp.on) && bkp.cal_on == $past(bkp.cal_on)))
        else $error("backup field changed without write permission");

    a_bkp_wait_bound: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !CE_IN)
        (req && hit_bkp && AVS_WAITREQUEST_OUT) |-> ##[1:3] !AVS_WAITREQUEST_OUT)
        else $error("backup register stalled beyond three cycles");

    a_swreset_clears: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp.sw_reset && CE_IN) |=> (!bkp.on && !bkp.cal_on && bkp.src == 2'h0 && !bkp.bypass))
        else $error("backup domain fields survived the software reset");

    a_src_locked: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp.src != 2'h0 && !bkp.sw_reset) |=> (bkp.src == $past(bkp.src)))
        else $error("calendar source changed after selection");

    a_bypass_locked: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp.on && !bkp.sw_reset) |=> (bkp.bypass == $past(bkp.bypass)))
        else $error("bypass changed while the crystal ran");

    a_ready_hold: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        ($fell(bkp.ready) && !$past(bkp.on) && !$past(bkp.sw_reset))
        |-> ($past(bkp.drop_cnt) == 3'(READY_DROP - 1)))
        else $error("ready fell before the drop count");

    a_ready_source: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        $rose(bkp.ready) |-> ($past(bkp.on) && $past(bkp.stable_sync)))
        else $error("ready rose without an enabled stable crystal");

    a_bkp_reserved_zero: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (AVS_READ_IN && hit_bkp) |-> (AVS_READDATA_OUT[31:17] == 15'h0
                                      && AVS_READDATA_OUT[14:10] == 5'h0
                                      && AVS_READDATA_OUT[7:3] == 5'h0))
        else $error("reserved backup bits read as one");

    a_gate_write_lands: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (done && AVS_WRITE_IN && hit_gates && AVS_BYTEENABLE_IN == 4'hf)
        |=> (sys.gates == ($past(AVS_WRITEDATA_IN) & pcg_pkg::GATES_RW_MASK)))
        else $error("full word write to the gate register did not land");

    a_gate_out_hold: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !(done && AVS_WRITE_IN && hit_gates) |=> $stable(PERIPH_CLK_ON_OUT))
        else $error("clock gates moved without a gate register write");

    a_gate_readback: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (AVS_READ_IN && hit_gates) |-> (AVS_READDATA_OUT == 32'(PERIPH_CLK_ON_OUT)))
        else $error("gate register read differs from the driven gates");

    a_gated_read_pass: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && sys.gates[PERIPH_SEL_IN]) |=> (PERIPH_RDATA_OUT == $past(PERIPH_RDATA_IN)))
        else $error("read data of a clocked peripheral was not passed on");

    a_unmapped_quiet: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (req && CE_IN && !hit_gates && !hit_bkp)
        |-> (!AVS_WAITREQUEST_OUT && AVS_READDATA_OUT == 32'h00000000))
        else $error("unmapped access stalled or returned data");

    a_bkp_back_stall: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (done && hit_bkp) |=> (!(req && hit_bkp) || AVS_WAITREQUEST_OUT))
        else $error("successive backup access was not stalled");

    a_gap_count_down: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && sys.gap != 2'h0 && !(done && hit_bkp))
        |=> (sys.gap == $past(sys.gap) - 2'h1))
        else $error("backup spacing counter did not count down");

    // The field checks below leave out the software reset, which overrides every field it clears.
    a_swreset_write: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        bkp_write |=> (bkp.sw_reset == $past(bkp_merged[pcg_pkg::SWRST_BIT])))
        else $error("backup reset bit did not follow its write");

    a_cal_on_write: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp_write && BACKUP_WRITE_PERMIT_IN && !bkp.sw_reset)
        |=> (bkp.cal_on == $past(bkp_merged[pcg_pkg::CAL_ON_BIT])))
        else $error("calendar clock enable did not follow a permitted write");

    a_xtal_on_write: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp_write && BACKUP_WRITE_PERMIT_IN && !bkp.sw_reset)
        |=> (bkp.on == $past(bkp_merged[pcg_pkg::ON_BIT])))
        else $error("crystal enable did not follow a permitted write");

    a_src_first_pick: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp_write && BACKUP_WRITE_PERMIT_IN && !bkp.sw_reset && bkp.src == pcg_pkg::SRC_NONE)
        |=> (bkp.src == $past(bkp_merged[pcg_pkg::SRC_LSB +: 2])))
        else $error("first calendar source choice was not taken");

    a_bypass_write: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp_write && BACKUP_WRITE_PERMIT_IN && !bkp.sw_reset && !bkp.on)
        |=> (bkp.bypass == $past(bkp_merged[pcg_pkg::BYP_BIT])))
        else $error("bypass write with the crystal off was lost");

    a_ready_follow_on: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (CE_IN && bkp.on && !bkp.sw_reset) |=> (bkp.ready == $past(bkp.stable_sync)))
        else $error("ready did not follow the synchronised stability input");

    a_ready_stays_low: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (!bkp.on && !bkp.ready) |=> !bkp.ready)
        else $error("ready rose with the crystal switched off");

    a_drop_cnt_bound: assert property (@(posedge CLK_IN) disable iff (!BKP_NRST_IN)
        (bkp.drop_cnt <= 3'(READY_DROP - 1)))
        else $error("ready drop counter ran past its limit");

    a_bkp_readback: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (AVS_READ_IN && hit_bkp) |-> ({AVS_READDATA_OUT[16:15], AVS_READDATA_OUT[9:8], AVS_READDATA_OUT[2],
                                      AVS_READDATA_OUT[0], AVS_READDATA_OUT[1]} == 7'(BACKUP_CTL_OUT)))
        else $error("backup register read differs from the driven controls");
endmodule // pcg_clock_gate_ctl
`default_nettype wire

/* File: hdl/pcg_pkg.sv */
// Constants and carrier types for the peripheral clock gate and backup control block.
package pcg_pkg;
    // ==================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] GATES_OFS = 8'h1c;
    localparam logic [7:0] BKP_OFS = 8'h20;
    localparam logic [31:0] GATES_RESET = 32'h00000000;
    localparam logic [31:0] GATES_RW_MASK = 32'h787ec9ff;
    // ==================================================
    // Backup control field positions
    localparam int SWRST_BIT = 16;
    localparam int CAL_ON_BIT = 15;
    localparam int SRC_LSB = 8;
    localparam int BYP_BIT = 2;
    localparam int RDY_BIT = 1;
    localparam int ON_BIT = 0;
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_SLOW_EXT = 2'h1;
    localparam logic [1:0] SRC_SLOW_INT = 2'h2;
    localparam logic [1:0] SRC_FAST_DIV = 2'h3;
    // ==================================================
    // Timing counts
    localparam int BKP_MAX_WAIT = 3;
    localparam int XTAL_DROP_EDGES = 6;
    // ==================================================
    // Carriers
    typedef struct packed {
        logic res31;
        logic consumer_ctl_clk_on;
        logic analog_out_if_clk_on;
        logic power_if_clk_on;
        logic backup_if_clk_on;
        logic [3:0] res26_23;
        logic second_i2c_clk_on;
        logic first_i2c_clk_on;
        logic async_port_b_clk_on;
        logic async_port_a_clk_on;
        logic serial_port_c_clk_on;
        logic serial_port_b_clk_on;
        logic res16;
        logic third_spi_clk_on;
        logic second_spi_clk_on;
        logic [1:0] res13_12;
        logic window_dog_clk_on;
        logic [1:0] res10_9;
        logic [8:0] timer_clk_on;
    } pcg_gates_s;
    typedef struct packed {
        logic backup_domain_sw_reset;
        logic calendar_clk_on;
        logic [1:0] calendar_clk_source;
        logic slow_xtal_bypass;
        logic slow_xtal_on;
        logic slow_xtal_ready;
    } pcg_bkp_out_s;
endpackage

/* File: testbench/pcg_far_model.sv */
// Far side model: slow crystal oscillator and a gated peripheral's read data.
`timescale 1ns/100ps
`default_nettype none
module pcg_far_model (
    input wire logic xtal_on_in,
    input wire logic [4:0] sel_in,
    output logic stable_out,
    output logic xclk_out,
    output logic [31:0] rdata_out
);
    // ==================================================
    // Peripheral read data
    // Each select gives its own word, so a wrong select cannot pass unseen.
    assign rdata_out = {3'h5, sel_in, 24'h3c96a1};
    // ==================================================
    // Slow crystal
    // It settles after eight of its own cycles and runs on for ten after switch-off, so the ready drop
    // is timed by real crystal edges and not by a stability input that falls at once.
    int on_cnt;
    int off_cnt;
    initial begin
        xclk_out = 1'b0;
        stable_out = 1'b0;
        on_cnt = 0;
        off_cnt = 0;
        forever begin
            #170;
            if (xtal_on_in === 1'b1 || off_cnt < 10 || xclk_out) begin
                xclk_out = ~xclk_out;
            end
            if (xclk_out && xtal_on_in === 1'b1) begin
                off_cnt = 0;
                on_cnt++;
                stable_out = (on_cnt >= 8);
            end else if (xclk_out) begin
                on_cnt = 0;
                off_cnt++;
                if (off_cnt >= 10) begin
                    stable_out = 1'b0;
                end
            end
        end
    end
endmodule // pcg_far_model
`default_nettype wire

/* File: testbench/pcg_clock_gate_ctl_bench.sv */
// Self-checking bench for the peripheral clock gate and backup control block.
`timescale 1ns/100ps
`default_nettype none
module pcg_clock_gate_ctl_bench;
    localparam int GAP = 3;
    localparam logic [7:0] GOF = pcg_pkg::GATES_OFS;
    localparam logic [7:0] BOF = pcg_pkg::BKP_OFS;
    logic clk, nrst, bkp_nrst, rd_en, wr_en, wreq, busy, permit, stable, xclk, ce;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, prd_in, prd_out, seen;
    logic [3:0] be;
    logic [4:0] sel;
    pcg_pkg::pcg_gates_s gates;
    pcg_pkg::pcg_bkp_out_s bko;
    int err_total, checks_done, waits;
    // ==================================================
    // Design and far side
    pcg_clock_gate_ctl #(.BKP_GAP(GAP), .READY_DROP(6)) DUT (
        .CLK_IN(clk), .NRST_IN(nrst), .BKP_NRST_IN(bkp_nrst), .CE_IN(ce),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wreq), .PERIPH_BUS_BUSY_IN(busy), .BACKUP_WRITE_PERMIT_IN(permit),
        .SLOW_XTAL_STABLE_IN(stable), .SLOW_XTAL_CLK_IN(xclk), .PERIPH_SEL_IN(sel),
        .PERIPH_RDATA_IN(prd_in), .PERIPH_RDATA_OUT(prd_out), .PERIPH_CLK_ON_OUT(gates),
        .BACKUP_CTL_OUT(bko));
    pcg_far_model far (.xtal_on_in(bko.slow_xtal_on), .sel_in(sel), .stable_out(stable),
        .xclk_out(xclk), .rdata_out(prd_in));
    // ==================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask
    // Called just after an edge; holds the request until waitrequest is seen low and leaves it up,
    // so two calls in a row make back-to-back requests.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        int i;
        rd_en <= !w;
        wr_en <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        waits = 0;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
            waits++;
        end
        seen = rdata;
        if (i == 200) err_total++;
    endtask
    task automatic idle();
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        acc(1'b1, a, d, b);
        idle();
    endtask
    task automatic rd(input logic [7:0] a);
        acc(1'b0, a, 32'h0, 4'hf);
        idle();
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ==================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
    // ==================================================
    // Tests
    initial begin
        {nrst, bkp_nrst, rd_en, wr_en, busy, permit, ce} = 7'h01;
        {addr, wdata, be, sel} = 49'h0;
        err_total = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        bkp_nrst <= 1'b1;
        @(posedge clk);
        rd(GOF); check(seen, pcg_pkg::GATES_RESET);
        check(waits, 0);
        rd(BOF); check(seen, 32'h0);
        rd(8'h40); check(seen, 32'h0);
        wr(GOF, 32'hffffffff, 4'hf); check(gates, pcg_pkg::GATES_RW_MASK);
        rd(GOF); check(seen, pcg_pkg::GATES_RW_MASK);
        wr(GOF, 32'h0, 4'hf);
        wr(GOF, 32'hffffffff, 4'h1);
        rd(GOF); check(seen, 32'h000000ff);
        wr(GOF, 32'hffffffff, 4'hc);
        busy <= 1'b1;
        fork
            begin
                repeat (4) @(posedge clk);
                busy <= 1'b0;
            end
            acc(1'b0, GOF, 32'h0, 4'hf);
        join
        idle();
        check(waits, 4);
        check(seen, 32'h787e00ff);
        ce <= 1'b0;
        fork
            begin
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
            acc(1'b1, GOF, 32'h00000800, 4'h2);
        join
        idle();
        check(waits, 3);
        check(gates, 32'h787e08ff);
        sel <= 5'd0;
        repeat (2) @(posedge clk);
        check(prd_out, {3'h5, 5'd0, 24'h3c96a1});
        sel <= 5'd15;
        repeat (2) @(posedge clk);
        check(prd_out, 32'h0);
        wr(BOF, 32'h00008105, 4'hf);
        rd(BOF); check(seen, 32'h0);
        permit <= 1'b1;
        repeat (5) @(posedge clk);
        acc(1'b0, BOF, 32'h0, 4'hf); check(waits, 0);
        acc(1'b0, BOF, 32'h0, 4'hf); check(waits, GAP);
        idle();
        for (int s = 0; s < 4; s++) begin
            wr(BOF, 32'h00010000, 4'hf);
            @(posedge clk);
            check({25'h0, bko}, 32'h40);
            wr(BOF, 32'h0, 4'h4);
            wr(BOF, 32'(s) << 8, 4'h2);
            rd(BOF); check(seen, 32'(s) << 8);
        end
        wr(BOF, 32'h00000100, 4'h2);
        rd(BOF); check(seen, 32'h00000300);
        wr(BOF, 32'h00010000, 4'h4);
        wr(BOF, 32'h0, 4'h4);
        wr(BOF, 32'h00008101, 4'hf);
        for (int i = 0; i < 300 && bko.slow_xtal_ready !== 1'b1; i++) @(posedge clk);
        rd(BOF); check(seen, 32'h00008103);
        wr(BOF, 32'h00008105, 4'h1);
        rd(BOF); check(seen, 32'h00008103);
        wr(BOF, 32'h00008100, 4'h1);
        repeat (4) @(posedge xclk);
        check(bko.slow_xtal_ready, 1'b1);
        repeat (3) @(posedge xclk);
        repeat (4) @(posedge clk);
        check(bko.slow_xtal_ready, 1'b0);
        wr(BOF, 32'h00008104, 4'h1);
        rd(BOF); check(seen, 32'h00008104);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(BOF); check(seen, 32'h00008104);
        rd(GOF); check(seen, 32'h0);
        bkp_nrst <= 1'b0;
        @(posedge clk);
        bkp_nrst <= 1'b1;
        @(posedge clk);
        rd(BOF); check(seen, 32'h0);
        wr(BOF, 32'hfffefffa, 4'hf);
        rd(BOF); check(seen, 32'h00008300);
        report_and_stop();
    end
endmodule // pcg_clock_gate_ctl_bench
`default_nettype wire
